// file: verilog/cmd_engine_cfg.svh
`ifndef CMD_ENGINE_CFG_SVH
`define CMD_ENGINE_CFG_SVH
// opcodes, low byte of doubleword 0
`define OP_CLEAR_PEND 8'h04
`define OP_DROP_EVENT 8'h0F
`define OP_RAISE_PEND 8'h03
`define OP_REFRESH_EVT 8'h0C
`define OP_REFRESH_GRP 8'h0D
`define OP_BIND_GROUP 8'h09
`define OP_BIND_SOURCE 8'h08
`define OP_BIND_IDENT 8'h0B
`define OP_BIND_EXPL 8'h0A
`define OP_MIGRATE 8'h0E
`define OP_REHOME 8'h01
// packet field positions
`define PKT_BITS 256
`define F_OP_LO 0
`define F_SRC_LO 32
`define F_EVT_LO 64
`define F_IRQ_LO 96
`define F_SIZE_LO 64
`define F_GRP_LO 128
`define F_LOC_LO 144
`define F_LOC2_LO 208
`define F_VALID 191
`define LOC_W 36
`define MIN_MSG_IRQ 32'h0000_2000
// router operations
`define RT_NONE 3'h0
`define RT_SET 3'h1
`define RT_CLEAR 3'h2
`define RT_REFRESH_EVT 3'h3
`define RT_REFRESH_GRP 3'h4
`define RT_MIGRATE 3'h5
`define RT_MOVE 3'h6
`define RT_DROP 3'h7
// error check numbers, first failing check wins
`define E_NONE 3'h0
`define E_SRC_OOR 3'h1
`define E_SRC_UNBOUND 3'h2
`define E_EVT_OOR 3'h3
`define E_NO_GROUP 3'h4
`define E_NO_TARGET 3'h5
`define E_ROUTER 3'h6
`define E_BAD_ARG 3'h7
`endif

// file: verilog/cmd_engine_pkg.sv
package cmd_engine_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_FETCH = 2'h1,
    S_EXEC = 2'h3,
    S_WAIT = 2'h2
  } state_type;
  typedef enum logic [1:0] {
    POL_IGNORE = 2'h0,
    POL_STALL = 2'h1,
    POL_AS_VALID = 2'h2
  } err_policy_type;
endpackage

// file: verilog/interrupt_translation_cmd_engine.sv
// How it works
// - clear-pending: translate, router clears pending
// - drop: clear, refresh, invalidate map entry
// - raise-pending: translate, router sets pending
// - event refresh: router syncs event caching
// - group refresh: routers sync group caching
// - bind group: group entry points at target
// - bind source: store table base and size
// - identity bind: irq number equals event number
// - explicit bind: stores group, irq at least 0x2000
// - migrate: first router moves all to second
// - rehome: new group, move pending state
// - widths readable; excess argument bits zero
// - message irqs from 8192 up to width
// - locator: address bits 51:16 or core
// - group count: onchip plus memory, capped
// - source and event ranges bounded
// - ignore: no action, advance pointer, error
// - stall: hold pointer, set halted, error
// - as valid: execute, advance, error
// - drop/clear errors checked in order
// - 32-byte packets of four doublewords
// - equal pointers mean empty queue
// - halted means no further commands
`timescale 1ns/1ps
`include "cmd_engine_cfg.svh"
module interrupt_translation_cmd_engine #(
  parameter int SRC_W = 4,
  parameter int EVT_W = 4,
  parameter int GID_W = 4,
  parameter int IRQ_W = 16,
  parameter int QPTR_W = 8,
  parameter int ONCHIP_GROUPS = 8,
  parameter int MEM_GROUPS = 8,
  parameter bit GROUP_LIMIT = 1'b1,
  parameter bit TARGET_FORMAT = 1'b1,
  parameter bit SYS_ERR_SUPPORT = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [QPTR_W-1:0] cmd_write_ptr_in,
  input wire logic [QPTR_W-1:0] queue_entries_in,
  input wire logic cmd_retry_in,
  input wire logic [1:0] err_policy_in,
  output logic [QPTR_W-1:0] cmd_read_ptr_out,
  output logic halted_out,
  output logic cmd_fetch_req_out,
  output logic [QPTR_W-1:0] cmd_fetch_idx_out,
  input wire logic cmd_pkt_valid_in,
  input wire logic [`PKT_BITS-1:0] cmd_pkt_in,
  output logic rtr_req_out,
  output logic [2:0] rtr_op_out,
  output logic [`LOC_W-1:0] rtr_target_out,
  output logic [`LOC_W-1:0] rtr_target2_out,
  output logic [IRQ_W-1:0] rtr_irq_out,
  input wire logic rtr_ack_in,
  input wire logic rtr_ok_in,
  output logic sys_error_out,
  output logic [2:0] err_code_out,
  output logic [5:0] source_id_width_out,
  output logic [5:0] event_id_width_out,
  output logic target_format_flag_out
);
  localparam int MAP_N = 1 << (SRC_W + EVT_W);
  localparam int GRP_RAW = ONCHIP_GROUPS + MEM_GROUPS;
  localparam int GRP_N = (GROUP_LIMIT && GRP_RAW > (1 << GID_W)) ?
    (1 << GID_W) : GRP_RAW;

  initial begin
    // the map table holds one on-chip entry per source and event pair
    if (SRC_W < 1 || EVT_W < 1 || GID_W < 1 || IRQ_W < 14 ||
        SRC_W + EVT_W > 16 || GRP_N < 1 || GRP_N > (1 << GID_W))
      $error("unsupported engine parameters");
  end

  cmd_engine_pkg::state_type state_r;
  logic [`PKT_BITS-1:0] pkt_r;
  logic [QPTR_W-1:0] rd_ptr_r;
  logic halted_r;
  logic src_valid_r [1<<SRC_W];
  logic [4:0] src_size_r [1<<SRC_W];
  logic [43:0] src_base_r [1<<SRC_W];
  logic map_valid_r [MAP_N];
  logic [GID_W-1:0] map_grp_r [MAP_N];
  logic [IRQ_W-1:0] map_irq_r [MAP_N];
  logic grp_valid_r [GRP_N];
  logic [`LOC_W-1:0] grp_loc_r [GRP_N];

  // decoded fields, argument bits above the widths read as zero
  logic [7:0] op;
  logic [31:0] src_raw, evt_raw, irq_raw, grp_raw, ngrp_raw;
  logic [SRC_W-1:0] src;
  logic [EVT_W-1:0] evt;
  logic [GID_W-1:0] grp;
  logic [SRC_W+EVT_W-1:0] mi;
  logic [GID_W-1:0] tgrp;
  logic [4:0] size;
  logic [`LOC_W-1:0] loc, loc2;
  logic [2:0] err;
  logic [2:0] rt_op;
  logic writes_tables;

  function automatic logic [QPTR_W-1:0] next_ptr(
    input logic [QPTR_W-1:0] p, input logic [QPTR_W-1:0] n);
    next_ptr = (p + 1'b1 >= n) ? '0 : p + 1'b1;
  endfunction

  function automatic logic grp_oor(input logic [31:0] g);
    grp_oor = g >= GRP_N;
  endfunction

  always_comb begin
    op = pkt_r[`F_OP_LO +: 8];
    src_raw = pkt_r[`F_SRC_LO +: 32];
    evt_raw = pkt_r[`F_EVT_LO +: 32];
    irq_raw = pkt_r[`F_IRQ_LO +: 32];
    grp_raw = {16'h0000, pkt_r[`F_GRP_LO +: 16]};
    ngrp_raw = grp_raw;
    size = pkt_r[`F_SIZE_LO +: 5];
    src = src_raw[SRC_W-1:0];
    evt = evt_raw[EVT_W-1:0];
    grp = grp_raw[GID_W-1:0];
    mi = {src, evt};
    tgrp = map_grp_r[mi];
    // core number form keeps only the low field bits
    loc = pkt_r[`F_LOC_LO +: `LOC_W];
    loc2 = pkt_r[`F_LOC2_LO +: `LOC_W];
    if (!TARGET_FORMAT) begin
      loc = {20'h00000, loc[15:0]};
      loc2 = {20'h00000, loc2[15:0]};
    end
    err = `E_NONE;
    rt_op = `RT_NONE;
    writes_tables = 1'b0;
    case (op)
      `OP_CLEAR_PEND, `OP_DROP_EVENT, `OP_RAISE_PEND,
      `OP_REFRESH_EVT, `OP_REFRESH_GRP: begin
        if (op == `OP_REFRESH_GRP) begin
          if (grp_oor(grp_raw)) err = `E_BAD_ARG;
          else if (!grp_valid_r[grp]) err = `E_NO_TARGET;
        end else if (src_raw >> SRC_W != 32'h0)
          err = `E_SRC_OOR;
        else if (!src_valid_r[src]) err = `E_SRC_UNBOUND;
        else if (evt_raw >> (src_size_r[src] + 1) != 32'h0)
          err = `E_EVT_OOR;
        else if (!map_valid_r[mi]) err = `E_NO_GROUP;
        else if (!grp_valid_r[tgrp]) err = `E_NO_TARGET;
        case (op)
          `OP_CLEAR_PEND: rt_op = `RT_CLEAR;
          `OP_DROP_EVENT: rt_op = `RT_DROP;
          `OP_RAISE_PEND: rt_op = `RT_SET;
          `OP_REFRESH_EVT: rt_op = `RT_REFRESH_EVT;
          default: rt_op = `RT_REFRESH_GRP;
        endcase
        writes_tables = op == `OP_DROP_EVENT;
      end
      `OP_REHOME: begin
        if (src_raw >> SRC_W != 32'h0) err = `E_SRC_OOR;
        else if (!src_valid_r[src]) err = `E_SRC_UNBOUND;
        else if (evt_raw >> (src_size_r[src] + 1) != 32'h0)
          err = `E_EVT_OOR;
        else if (!map_valid_r[mi]) err = `E_NO_GROUP;
        else if (!grp_valid_r[tgrp]) err = `E_NO_TARGET;
        else if (grp_oor(ngrp_raw) || !grp_valid_r[grp])
          err = `E_BAD_ARG;
        rt_op = `RT_MOVE;
        writes_tables = 1'b1;
      end
      `OP_BIND_GROUP: begin
        if (grp_oor(grp_raw)) err = `E_BAD_ARG;
        writes_tables = 1'b1;
      end
      `OP_BIND_SOURCE: begin
        if (src_raw >> SRC_W != 32'h0) err = `E_SRC_OOR;
        else if (size > 5'(EVT_W - 1)) err = `E_BAD_ARG;
        writes_tables = 1'b1;
      end
      `OP_BIND_IDENT, `OP_BIND_EXPL: begin
        if (op == `OP_BIND_IDENT) irq_raw = evt_raw;
        if (src_raw >> SRC_W != 32'h0) err = `E_SRC_OOR;
        else if (!src_valid_r[src]) err = `E_SRC_UNBOUND;
        else if (evt_raw >> (src_size_r[src] + 1) != 32'h0)
          err = `E_EVT_OOR;
        else if (grp_oor(grp_raw)) err = `E_BAD_ARG;
        else if (irq_raw < `MIN_MSG_IRQ || irq_raw >> IRQ_W != 32'h0)
          err = `E_BAD_ARG;
        writes_tables = 1'b1;
      end
      `OP_MIGRATE: rt_op = `RT_MIGRATE;
      default: err = `E_BAD_ARG;
    endcase
  end

  logic bad, stall, run;
  logic [1:0] pol;
  assign pol = err_policy_in;
  assign bad = err != `E_NONE;
  assign stall = bad && pol == cmd_engine_pkg::POL_STALL;
  // an ignored command changes nothing; a stalled one neither
  assign run = !bad || pol == cmd_engine_pkg::POL_AS_VALID;

  // sequencing: fetch, execute, wait for the router, next
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= cmd_engine_pkg::S_IDLE;
      cmd_fetch_req_out <= 1'b0;
      pkt_r <= '0;
    end else begin
      case (state_r)
        cmd_engine_pkg::S_IDLE: begin
          if (!halted_r && rd_ptr_r != cmd_write_ptr_in) begin
            state_r <= cmd_engine_pkg::S_FETCH;
            cmd_fetch_req_out <= 1'b1;
          end
        end
        cmd_engine_pkg::S_FETCH: begin
          if (cmd_pkt_valid_in) begin
            pkt_r <= cmd_pkt_in;
            cmd_fetch_req_out <= 1'b0;
            state_r <= cmd_engine_pkg::S_EXEC;
          end
        end
        cmd_engine_pkg::S_EXEC: begin
          if (run && rt_op != `RT_NONE) state_r <= cmd_engine_pkg::S_WAIT;
          else state_r <= cmd_engine_pkg::S_IDLE;
        end
        cmd_engine_pkg::S_WAIT: begin
          if (rtr_ack_in) state_r <= cmd_engine_pkg::S_IDLE;
        end
        default: state_r <= cmd_engine_pkg::S_IDLE;
      endcase
    end
  end

  // read pointer and halted flag
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_ptr_r <= '0;
      halted_r <= 1'b0;
    end else begin
      if (state_r == cmd_engine_pkg::S_EXEC) begin
        if (stall) halted_r <= 1'b1;
        else if (rt_op == `RT_NONE || !run)
          rd_ptr_r <= next_ptr(rd_ptr_r, queue_entries_in);
      end else if (state_r == cmd_engine_pkg::S_WAIT && rtr_ack_in) begin
        // a router refusal under the stall policy holds the entry
        if (!rtr_ok_in && pol == cmd_engine_pkg::POL_STALL)
          halted_r <= 1'b1;
        else rd_ptr_r <= next_ptr(rd_ptr_r, queue_entries_in);
      end else if (halted_r && cmd_retry_in) begin
        halted_r <= 1'b0;
      end
    end
  end

  // translation tables
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < (1 << SRC_W); i++) begin
        src_valid_r[i] <= 1'b0;
        src_size_r[i] <= '0;
        src_base_r[i] <= '0;
      end
      for (int i = 0; i < MAP_N; i++) begin
        map_valid_r[i] <= 1'b0;
        map_grp_r[i] <= '0;
        map_irq_r[i] <= '0;
      end
      for (int i = 0; i < GRP_N; i++) begin
        grp_valid_r[i] <= 1'b0;
        grp_loc_r[i] <= '0;
      end
    end else if (state_r == cmd_engine_pkg::S_EXEC && run &&
                 writes_tables) begin
      case (op)
        `OP_BIND_GROUP: begin
          grp_valid_r[grp] <= pkt_r[`F_VALID];
          grp_loc_r[grp] <= loc;
        end
        `OP_BIND_SOURCE: begin
          src_valid_r[src] <= pkt_r[`F_VALID];
          src_size_r[src] <= size;
          src_base_r[src] <= pkt_r[`F_GRP_LO + 8 +: 44];
        end
        `OP_BIND_IDENT, `OP_BIND_EXPL: begin
          map_valid_r[mi] <= 1'b1;
          map_grp_r[mi] <= grp;
          map_irq_r[mi] <= irq_raw[IRQ_W-1:0];
        end
        // later requests on an invalid entry fail with E_NO_GROUP
        `OP_DROP_EVENT: map_valid_r[mi] <= 1'b0;
        `OP_REHOME: map_grp_r[mi] <= grp;
        default: ;
      endcase
    end
  end

  // router request, held until acknowledged
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rtr_req_out <= 1'b0;
      rtr_op_out <= `RT_NONE;
      rtr_target_out <= '0;
      rtr_target2_out <= '0;
      rtr_irq_out <= '0;
    end else if (state_r == cmd_engine_pkg::S_EXEC && run &&
                 rt_op != `RT_NONE) begin
      rtr_req_out <= 1'b1;
      rtr_op_out <= rt_op;
      rtr_irq_out <= map_irq_r[mi];
      rtr_target_out <= op == `OP_MIGRATE ? loc :
        op == `OP_REFRESH_GRP ? grp_loc_r[grp] : grp_loc_r[tgrp];
      rtr_target2_out <= op == `OP_MIGRATE ? loc2 :
        grp_loc_r[grp];
    end else if (rtr_ack_in) begin
      rtr_req_out <= 1'b0;
    end
  end

  // system error pulse and status
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sys_error_out <= 1'b0;
      err_code_out <= `E_NONE;
    end else begin
      sys_error_out <= 1'b0;
      if (state_r == cmd_engine_pkg::S_EXEC && bad) begin
        sys_error_out <= SYS_ERR_SUPPORT;
        err_code_out <= err;
      end else if (state_r == cmd_engine_pkg::S_WAIT && rtr_ack_in &&
                   !rtr_ok_in) begin
        sys_error_out <= SYS_ERR_SUPPORT;
        err_code_out <= `E_ROUTER;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      source_id_width_out <= 6'(SRC_W);
      event_id_width_out <= 6'(EVT_W);
      target_format_flag_out <= TARGET_FORMAT;
    end
  end

  assign cmd_read_ptr_out = rd_ptr_r;
  assign halted_out = halted_r;
  assign cmd_fetch_idx_out = rd_ptr_r;

  property p_empty;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_IDLE && rd_ptr_r == cmd_write_ptr_in
    |=> !cmd_fetch_req_out;
  endproperty
  a_empty: assert property (p_empty)
    else $error("fetch started on an empty queue");

  property p_halt;
    @(posedge clk_in) disable iff (reset_in)
    halted_r && !cmd_retry_in |=> !cmd_fetch_req_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("fetch while halted");

  property p_stall;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC && stall
    |=> halted_r && $stable(rd_ptr_r);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall did not hold the pointer");

  property p_ignore;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC && bad &&
    pol == cmd_engine_pkg::POL_IGNORE
    |=> rd_ptr_r == next_ptr($past(rd_ptr_r), queue_entries_in) &&
        !rtr_req_out;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored command acted or did not advance");

  property p_syserr;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC && bad
    |=> sys_error_out == SYS_ERR_SUPPORT;
  endproperty
  a_syserr: assert property (p_syserr)
    else $error("system error not raised");

  property p_raise;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC && !bad && op == `OP_RAISE_PEND
    |=> rtr_req_out && rtr_op_out == `RT_SET;
  endproperty
  a_raise: assert property (p_raise)
    else $error("raise-pending not sent to router");

  property p_minirq;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC && op == `OP_BIND_EXPL &&
    src_raw >> SRC_W == 32'h0 && irq_raw < `MIN_MSG_IRQ |-> bad;
  endproperty
  a_minirq: assert property (p_minirq)
    else $error("low irq number accepted");

  property p_resume;
    @(posedge clk_in) disable iff (reset_in)
    halted_r && cmd_retry_in && state_r == cmd_engine_pkg::S_IDLE
    |=> !halted_r;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not clear halted");

  property p_order;
    @(posedge clk_in) disable iff (reset_in)
    rtr_req_out && !rtr_ack_in |=> $stable(rd_ptr_r) && !cmd_fetch_req_out;
  endproperty
  a_order: assert property (p_order)
    else $error("next command began before router answered");

  property p_unknown;
    @(posedge clk_in) disable iff (reset_in)
    state_r == cmd_engine_pkg::S_EXEC &&
    !(op inside {`OP_CLEAR_PEND, `OP_DROP_EVENT, `OP_RAISE_PEND,
      `OP_REFRESH_EVT, `OP_REFRESH_GRP, `OP_BIND_GROUP, `OP_BIND_SOURCE,
      `OP_BIND_IDENT, `OP_BIND_EXPL, `OP_MIGRATE, `OP_REHOME})
    |=> err_code_out == `E_BAD_ARG;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown opcode not flagged");
endmodule // interrupt_translation_cmd_engine

// file: dv/cmd_queue_router_model.sv
`timescale 1ns/1ps
// command memory and router stand-in; answers after 0 or 3 idle cycles
module cmd_queue_router_model #(
  parameter int QPTR_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic fetch_req_in,
  input wire logic [QPTR_W-1:0] fetch_idx_in,
  output logic pkt_valid_out,
  output logic [255:0] pkt_out,
  input wire logic rtr_req_in,
  input wire logic [2:0] rtr_op_in,
  input wire logic [35:0] rtr_target_in,
  input wire logic [35:0] rtr_target2_in,
  input wire logic [15:0] rtr_irq_in,
  output logic rtr_ack_out,
  output logic rtr_ok_out,
  input wire logic slow_in,
  input wire logic fail_in,
  output logic [2:0] last_op_out,
  output logic [15:0] last_irq_out,
  output logic [35:0] last_tgt_out,
  output logic [35:0] last_tgt2_out,
  output int op_cnt_out
);
  logic [255:0] mem [256];
  initial begin
    pkt_valid_out = 1'b0;
    pkt_out = '0;
    rtr_ack_out = 1'b0;
    rtr_ok_out = 1'b0;
    op_cnt_out = 0;
  end
  // one 32-byte packet per request, then the data lines stop holding it
  always begin : fetch_side
    @(posedge clk_in);
    #1;
    if (!reset_in && fetch_req_in) begin
      if (slow_in) repeat (3) @(posedge clk_in);
      if (slow_in) #1;
      pkt_valid_out = 1'b1;
      pkt_out = mem[fetch_idx_in];
      @(posedge clk_in);
      #1;
      pkt_valid_out = 1'b0;
      pkt_out = ~pkt_out;
    end
  end
  always begin : router_side
    @(posedge clk_in);
    #1;
    if (!reset_in && rtr_req_in) begin
      if (slow_in) repeat (3) @(posedge clk_in);
      if (slow_in) #1;
      rtr_ack_out = 1'b1;
      rtr_ok_out = !fail_in;
      last_op_out = rtr_op_in;
      last_irq_out = rtr_irq_in;
      last_tgt_out = rtr_target_in;
      last_tgt2_out = rtr_target2_in;
      op_cnt_out++;
      @(posedge clk_in);
      #1;
      rtr_ack_out = 1'b0;
      rtr_ok_out = ~rtr_ok_out;
    end
  end
endmodule // cmd_queue_router_model

// file: dv/interrupt_translation_cmd_engine_tb.sv
`timescale 1ns/1ps
`include "cmd_engine_cfg.svh"
module interrupt_translation_cmd_engine_tb;
  localparam logic [35:0] LOC_A = 36'h0_0001_2345;
  localparam logic [35:0] LOC_B = 36'hA_BCDE_F012;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cmd_retry_in = 1'b0;
  logic [7:0] wr = 8'h00;
  logic [7:0] entries = 8'h08;
  logic [1:0] pol = 2'h0;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic [7:0] rd, idx, held;
  logic halted, freq, pvld, rreq, ack, ok, serr, tflag;
  logic [255:0] pkt;
  logic [2:0] op, ecode, l_op;
  logic [35:0] tgt, tgt2, l_tgt, l_tgt2;
  logic [15:0] irq, l_irq;
  logic [5:0] sw, ew;
  int error_cnt = 0;
  int n_checks = 0;
  int se_cnt = 0;
  int op_cnt, se0, ops0;
  always #5 clk_in = ~clk_in;
  // counted mid-cycle, where the one-cycle pulse has settled
  always @(negedge clk_in) if (serr === 1'b1) se_cnt++;
  interrupt_translation_cmd_engine #(.SRC_W(2), .EVT_W(14),
    .GID_W(4)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .cmd_write_ptr_in(wr), .queue_entries_in(entries),
    .cmd_retry_in(cmd_retry_in), .err_policy_in(pol),
    .cmd_read_ptr_out(rd), .halted_out(halted), .cmd_fetch_req_out(freq),
    .cmd_fetch_idx_out(idx), .cmd_pkt_valid_in(pvld), .cmd_pkt_in(pkt),
    .rtr_req_out(rreq), .rtr_op_out(op), .rtr_target_out(tgt),
    .rtr_target2_out(tgt2), .rtr_irq_out(irq), .rtr_ack_in(ack),
    .rtr_ok_in(ok), .sys_error_out(serr), .err_code_out(ecode),
    .source_id_width_out(sw), .event_id_width_out(ew),
    .target_format_flag_out(tflag));
  cmd_queue_router_model model_u (.clk_in(clk_in),
    .reset_in(reset_in), .fetch_req_in(freq), .fetch_idx_in(idx),
    .pkt_valid_out(pvld), .pkt_out(pkt), .rtr_req_in(rreq),
    .rtr_op_in(op), .rtr_target_in(tgt), .rtr_target2_in(tgt2),
    .rtr_irq_in(irq), .rtr_ack_out(ack), .rtr_ok_out(ok), .slow_in(slow),
    .fail_in(fail), .last_op_out(l_op), .last_irq_out(l_irq),
    .last_tgt_out(l_tgt), .last_tgt2_out(l_tgt2), .op_cnt_out(op_cnt));
  function automatic logic [255:0] mk(logic [7:0] o, logic [31:0] s,
    logic [31:0] e, logic [31:0] n, logic [15:0] g, logic [35:0] l,
    logic [35:0] l2);
    logic [255:0] p;
    p = '0;
    p[7:0] = o;
    p[63:32] = s;
    p[95:64] = e;
    p[127:96] = n;
    p[143:128] = g;
    p[179:144] = l;
    p[191] = 1'b1;
    p[243:208] = l2;
    return p;
  endfunction
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic push(logic [255:0] p);
    @(posedge clk_in);
    #1;
    model_u.mem[wr] = p;
    wr = (wr + 8'h01) % entries;
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #1;
      if (halted === 1'b1 || rd === wr) break;
    end
    if (i == 300) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // routed: number of router operations the command must issue
  task automatic run(logic [255:0] p, logic [2:0] code, int routed);
    ops0 = op_cnt;
    se0 = se_cnt;
    push(p);
    wait_done();
    chk("fetch_req_idle", 64'h0, freq);
    chk("sys_error_pulses", (code != `E_NONE), se_cnt - se0);
    chk("router_ops", routed, op_cnt - ops0);
    if (code != `E_NONE) chk("err_code", code, ecode);
  endtask
  task automatic rt(logic [2:0] o, logic [15:0] n, logic [35:0] t,
    logic [35:0] t2);
    chk("rtr_op", o, l_op);
    chk("rtr_target", t, l_tgt);
    if (o != `RT_REFRESH_GRP && o != `RT_MIGRATE) chk("rtr_irq", n, l_irq);
    if (o == `RT_MIGRATE || o == `RT_MOVE) chk("rtr_target2", t2, l_tgt2);
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    chk("src_width", 64'h2, sw);
    chk("evt_width", 64'hE, ew);
    chk("target_flag", 64'h1, tflag);
    chk("read_ptr_reset", 64'h0, rd);
    run(mk(`OP_BIND_SOURCE, 1, 13, 0, 0, 0, 0), `E_NONE, 0);
    run(mk(`OP_BIND_GROUP, 0, 0, 0, 2, LOC_A, 0), `E_NONE, 0);
    run(mk(`OP_BIND_GROUP, 0, 0, 0, 3, LOC_B, 0), `E_NONE, 0);
    run(mk(`OP_BIND_EXPL, 1, 5, 32'h2005, 2, 0, 0), `E_NONE, 0);
    run(mk(`OP_RAISE_PEND, 1, 5, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_SET, 16'h2005, LOC_A, 0);
    slow = 1'b1;
    run(mk(`OP_CLEAR_PEND, 1, 5, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_CLEAR, 16'h2005, LOC_A, 0);
    run(mk(`OP_REFRESH_EVT, 1, 5, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_REFRESH_EVT, 16'h2005, LOC_A, 0);
    run(mk(`OP_REFRESH_GRP, 0, 0, 0, 3, 0, 0), `E_NONE, 1);
    rt(`RT_REFRESH_GRP, 0, LOC_B, 0);
    slow = 1'b0;
    run(mk(`OP_BIND_IDENT, 1, 32'h2003, 0, 2, 0, 0), `E_NONE, 0);
    run(mk(`OP_RAISE_PEND, 1, 32'h2003, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_SET, 16'h2003, LOC_A, 0);
    run(mk(`OP_REHOME, 1, 5, 0, 3, 0, 0), `E_NONE, 1);
    rt(`RT_MOVE, 16'h2005, LOC_A, LOC_B);
    run(mk(`OP_RAISE_PEND, 1, 5, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_SET, 16'h2005, LOC_B, 0);
    run(mk(`OP_MIGRATE, 0, 0, 0, 0, LOC_A, LOC_B), `E_NONE, 1);
    rt(`RT_MIGRATE, 0, LOC_A, LOC_B);
    run(mk(`OP_DROP_EVENT, 1, 32'h2003, 0, 0, 0, 0), `E_NONE, 1);
    rt(`RT_DROP, 16'h2003, LOC_A, 0);
    run(mk(`OP_RAISE_PEND, 1, 32'h2003, 0, 0, 0, 0), `E_NO_GROUP, 0);
    // ignore policy: each erroneous command is skipped
    run(mk(`OP_RAISE_PEND, 4, 5, 0, 0, 0, 0), `E_SRC_OOR, 0);
    run(mk(`OP_RAISE_PEND, 3, 5, 0, 0, 0, 0), `E_SRC_UNBOUND, 0);
    run(mk(`OP_BIND_SOURCE, 2, 3, 0, 0, 0, 0), `E_NONE, 0);
    run(mk(`OP_RAISE_PEND, 2, 32'h20, 0, 0, 0, 0), `E_EVT_OOR, 0);
    run(mk(`OP_BIND_EXPL, 1, 7, 32'h2007, 5, 0, 0), `E_NONE, 0);
    run(mk(`OP_CLEAR_PEND, 1, 7, 0, 0, 0, 0), `E_NO_TARGET, 0);
    run(mk(`OP_BIND_EXPL, 1, 8, 32'h1FFF, 2, 0, 0), `E_BAD_ARG, 0);
    // as-valid policy: a refused router request still advances
    pol = 2'h2;
    fail = 1'b1;
    run(mk(`OP_RAISE_PEND, 1, 5, 0, 0, 0, 0), `E_ROUTER, 1);
    fail = 1'b0;
    chk("halted_as_valid", 64'h0, halted);
    // stall policy: unknown opcode holds the queue
    pol = 2'h1;
    held = wr;
    se0 = se_cnt;
    push(mk(8'h55, 0, 0, 0, 0, 0, 0));
    wait_done();
    chk("halted", 64'h1, halted);
    chk("read_ptr_held", held, rd);
    chk("err_code_op", `E_BAD_ARG, ecode);
    chk("stall_sys_error", 64'h1, se_cnt - se0);
    ops0 = op_cnt;
    push(mk(`OP_RAISE_PEND, 1, 5, 0, 0, 0, 0));
    repeat (20) @(posedge clk_in);
    #1;
    chk("read_ptr_still", held, rd);
    chk("ops_while_halted", 64'h0, op_cnt - ops0);
    pol = 2'h0;
    cmd_retry_in = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_retry_in = 1'b0;
    wait_done();
    chk("halted_after_retry", 64'h0, halted);
    chk("ops_after_retry", 64'h1, op_cnt - ops0);
    chk("read_ptr_wrapped", wr, rd);
    report_and_stop();
  end
endmodule // interrupt_translation_cmd_engine_tb
